// ===== include/smart_pkg.sv
// How it works
// - autosave subcommand completes as a no-op, no state touched
// - read-data subcommand streams exactly one 512-byte sector to the host
// - bytes 0..1 carry structure version 0010h
// - thirty 12-byte attribute slots start at byte 2
// - two attributes are defined, one slot each
// - bytes 362..367 zero, bytes 368..369 hold capabilities 0003h
// - byte 370, 372..385 and 414..510 read zero
// - multi-byte fields go least significant byte first
// - bytes 386..387 carry vendor content version 0004h
// - byte 396 goes to 1 once global bad block management starts
// - byte 397 goes to 1 once global wear leveling starts
// - bytes 388..413 hold the six four-byte counters and two flag bytes
// - slot layout: id, flags, current value, worst value, raw bytes
// - spare attribute id C4h, value is min over chips of 100*cur/init
// - spare raw bytes 5..7 sum of initial, 8..10 sum of current, 11 zero
// - threshold exceeded whenever spare value is below spare threshold
// - both spare attributes carry flags 0003h
// - worst-chip attribute D5h, fixed 100, raw counts of chip with fewest spares
// - unsupported feature values are aborted
package smart_pkg;
    localparam logic [7:0] CMD_HEALTH = 8'hB0;
    localparam logic [7:0] SIG_CYL_HI = 8'hC2;
    localparam logic [7:0] FEAT_READ_DATA = 8'hD0;
    localparam logic [7:0] FEAT_READ_THR = 8'hD1;
    localparam logic [7:0] FEAT_AUTOSAVE = 8'hD2;
    localparam logic [7:0] FEAT_ENABLE = 8'hD8;
    localparam logic [7:0] FEAT_DISABLE = 8'hD9;
    localparam logic [7:0] FEAT_STATUS = 8'hDA;
    localparam int CMD_LSB = 0;
    localparam int FEAT_LSB = 8;
    localparam int CYLHI_LSB = 24;

    localparam logic [7:0] ADDR_CMD = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_DATA = 8'h08;
    localparam logic [7:0] ADDR_THRESH = 8'h0C;
    localparam logic [7:0] ADDR_FLAGS = 8'h10;
    localparam logic [7:0] ADDR_CNT0 = 8'h14;
    localparam logic [7:0] ADDR_INIT0 = 8'h30;
    localparam logic [7:0] ADDR_CUR0 = 8'h40;
    localparam int NCNT = 6;
    localparam int ST_BUSY = 0;
    localparam int ST_DONE = 1;
    localparam int ST_ABORT = 2;
    localparam int ST_THR = 3;
    localparam int FLG_GBB = 0;
    localparam int FLG_GWL = 1;

    localparam int CHIPS = 4;
    localparam int SPARE_W = 24;
    localparam logic [31:0] PCT_SCALE = 32'h0000_0064;
    localparam logic [7:0] PCT_FULL = 8'h64;

    localparam int WORDS = 128;
    localparam logic [6:0] LAST_WORD = 7'h7F;
    localparam logic [15:0] STRUCT_VER = 16'h0010;
    localparam logic [15:0] SMART_CAP = 16'h0003;
    localparam logic [15:0] VENDOR_VER = 16'h0004;
    localparam logic [7:0] ATTR_ID_SPARE = 8'hC4;
    localparam logic [7:0] ATTR_ID_WORST = 8'hD5;
    localparam logic [15:0] ATTR_FLAGS = 16'h0003;
    localparam logic [8:0] ATTR_BASE = 9'h002;
    localparam logic [8:0] ATTR_LEN = 9'h00C;
    localparam logic [8:0] ATTR_END = 9'h16A;
    localparam logic [8:0] OFS_OFFL_STAT = 9'h16A;
    localparam logic [8:0] OFS_CAP = 9'h170;
    localparam logic [8:0] OFS_POLL = 9'h174;
    localparam logic [8:0] OFS_VVER = 9'h182;
    localparam logic [8:0] OFS_COMMIT = 9'h184;
    localparam logic [8:0] OFS_WLTH = 9'h188;
    localparam logic [8:0] OFS_GBB = 9'h18C;
    localparam logic [8:0] OFS_GWL = 9'h18D;
    localparam logic [8:0] OFS_AVG = 9'h18E;
    localparam logic [8:0] OFS_FILL = 9'h19E;

    typedef enum logic [0:0] {
        ST_IDLE = 1'b0,
        ST_XFER = 1'b1
    } state_t;
endpackage

// ===== rtl/spare_calc.sv
`timescale 1ns/10ps
module spare_calc (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [smart_pkg::CHIPS-1:0][smart_pkg::SPARE_W-1:0] init_spare,
    input wire logic [smart_pkg::CHIPS-1:0][smart_pkg::SPARE_W-1:0] cur_spare,
    output logic [7:0] pct_q,
    output logic [smart_pkg::SPARE_W-1:0] sum_init_q,
    output logic [smart_pkg::SPARE_W-1:0] sum_cur_q,
    output logic [smart_pkg::SPARE_W-1:0] worst_init_q,
    output logic [smart_pkg::SPARE_W-1:0] worst_cur_q,
    output logic empty_q
);
    // a chip with no initial spares counts as full, avoiding a divide by zero
    function automatic logic [7:0] chip_pct(input logic [smart_pkg::SPARE_W-1:0] ini,
                                            input logic [smart_pkg::SPARE_W-1:0] cur);
        logic [31:0] q;
        q = smart_pkg::PCT_SCALE;
        if (ini != '0) begin
            q = (32'(cur) * smart_pkg::PCT_SCALE) / 32'(ini);
        end
        if (q > 32'(smart_pkg::PCT_FULL)) begin
            q = 32'(smart_pkg::PCT_FULL);
        end
        return q[7:0];
    endfunction

    logic [7:0] pct_d;
    logic [smart_pkg::SPARE_W-1:0] si_d, sc_d, wi_d, wc_d;
    logic empty_d;

    always_comb begin
        pct_d = smart_pkg::PCT_FULL;
        si_d = '0;
        sc_d = '0;
        wi_d = init_spare[0];
        wc_d = cur_spare[0];
        empty_d = 1'b0;
        for (int c = 0; c < smart_pkg::CHIPS; c++) begin
            if (chip_pct(init_spare[c], cur_spare[c]) < pct_d) begin
                pct_d = chip_pct(init_spare[c], cur_spare[c]);
            end
            // sums wrap at the three-byte field width
            si_d = si_d + init_spare[c];
            sc_d = sc_d + cur_spare[c];
            if (cur_spare[c] < wc_d) begin
                wi_d = init_spare[c];
                wc_d = cur_spare[c];
            end
            if (cur_spare[c] == '0 && init_spare[c] != '0) begin
                empty_d = 1'b1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pct_q <= smart_pkg::PCT_FULL;
            sum_init_q <= '0;
            sum_cur_q <= '0;
            worst_init_q <= '0;
            worst_cur_q <= '0;
            empty_q <= 1'b0;
        end else begin
            pct_q <= pct_d;
            sum_init_q <= si_d;
            sum_cur_q <= sc_d;
            worst_init_q <= wi_d;
            worst_cur_q <= wc_d;
            empty_q <= empty_d;
        end
    end
endmodule

// ===== rtl/smart_data_report.sv
// Local design decisions: the APB register port and the register addresses.
`timescale 1ns/10ps
module smart_data_report (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic thresh_exceeded
);
    smart_pkg::state_t state_q;
    logic [6:0] idx_q;
    logic [7:0] csum_q;
    logic done_q, abort_q;
    logic [7:0] thr_q;
    logic [1:0] flags_q;
    logic [7:0] worst_q;
    localparam int NCNT_TOP = smart_pkg::NCNT - 1;
    localparam int SPARE_BITS = smart_pkg::SPARE_W;
    logic [NCNT_TOP:0][31:0] cnt_q;
    logic [smart_pkg::CHIPS-1:0][smart_pkg::SPARE_W-1:0] init_q, cur_q;
    logic [7:0] pct;
    logic [smart_pkg::SPARE_W-1:0] sum_init, sum_cur, w_init, w_cur;
    logic chip_empty;

    spare_calc u_spare (
        .pclk(pclk),
        .presetn(presetn),
        .init_spare(init_q),
        .cur_spare(cur_q),
        .pct_q(pct),
        .sum_init_q(sum_init),
        .sum_cur_q(sum_cur),
        .worst_init_q(w_init),
        .worst_cur_q(w_cur),
        .empty_q(chip_empty)
    );

    function automatic logic [7:0] byte_of(input logic [31:0] v, input logic [1:0] k);
        logic [31:0] s;
        s = v >> {k, 3'b000};
        return s[7:0];
    endfunction

    function automatic logic [31:0] strb_merge(input logic [31:0] old, input logic [31:0] nw,
                                               input logic [3:0] st);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (st[b]) begin
                r[8*b +: 8] = nw[8*b +: 8];
            end
        end
        return r;
    endfunction

    function automatic logic [7:0] word_sum(input logic [31:0] w);
        return 8'(w[7:0] + w[15:8] + w[23:16] + w[31:24]);
    endfunction

    // one byte of the health sector; everything not named here is zero
    function automatic logic [7:0] sbyte(input logic [8:0] i);
        logic [8:0] r, slot, o;
        logic [8:0] d;
        logic [7:0] b;
        r = i - smart_pkg::ATTR_BASE;
        slot = r / smart_pkg::ATTR_LEN;
        o = r % smart_pkg::ATTR_LEN;
        d = i - smart_pkg::OFS_AVG;
        b = 8'h00;
        if (i < smart_pkg::ATTR_BASE) begin
            b = byte_of(32'(smart_pkg::STRUCT_VER), i[1:0]);
        end else if (i < smart_pkg::ATTR_END) begin
            if (slot == 9'h000) begin
                unique case (o)
                    9'h000: b = smart_pkg::ATTR_ID_SPARE;
                    9'h001: b = smart_pkg::ATTR_FLAGS[7:0];
                    9'h002: b = smart_pkg::ATTR_FLAGS[15:8];
                    9'h003: b = pct;
                    9'h004: b = worst_q;
                    9'h005, 9'h006, 9'h007: b = byte_of(32'(sum_init), 2'(o - 9'h005));
                    9'h008, 9'h009, 9'h00A: b = byte_of(32'(sum_cur), 2'(o - 9'h008));
                    default: b = 8'h00;
                endcase
            end else if (slot == 9'h001) begin
                unique case (o)
                    9'h000: b = smart_pkg::ATTR_ID_WORST;
                    9'h001: b = smart_pkg::ATTR_FLAGS[7:0];
                    9'h002: b = smart_pkg::ATTR_FLAGS[15:8];
                    9'h003, 9'h004: b = smart_pkg::PCT_FULL;
                    9'h005, 9'h006, 9'h007: b = byte_of(32'(w_init), 2'(o - 9'h005));
                    9'h008, 9'h009, 9'h00A: b = byte_of(32'(w_cur), 2'(o - 9'h008));
                    default: b = 8'h00;
                endcase
            end
        end else if (i == smart_pkg::OFS_CAP || i == smart_pkg::OFS_CAP + 9'h001) begin
            b = byte_of(32'(smart_pkg::SMART_CAP), i[1:0]);
        end else if (i == smart_pkg::OFS_VVER || i == smart_pkg::OFS_VVER + 9'h001) begin
            b = byte_of(32'(smart_pkg::VENDOR_VER), 2'(i - smart_pkg::OFS_VVER));
        end else if (i >= smart_pkg::OFS_COMMIT && i < smart_pkg::OFS_WLTH) begin
            b = byte_of(cnt_q[0], i[1:0]);
        end else if (i >= smart_pkg::OFS_WLTH && i < smart_pkg::OFS_GBB) begin
            b = byte_of(cnt_q[1], i[1:0]);
        end else if (i == smart_pkg::OFS_GBB) begin
            b = {7'h00, flags_q[smart_pkg::FLG_GBB]};
        end else if (i == smart_pkg::OFS_GWL) begin
            b = {7'h00, flags_q[smart_pkg::FLG_GWL]};
        end else if (i >= smart_pkg::OFS_AVG && i < smart_pkg::OFS_FILL) begin
            b = byte_of(cnt_q[2 + int'(d[3:2])], d[1:0]);
        end
        return b;
    endfunction

    logic access, done_acc, wr, rd;
    logic cmd_go, health, supported, data_rd, last_rd;
    logic [7:0] cmd_code, feat, cyl_hi;
    logic [31:0] data_word, rdata_d;
    logic err_d;
    logic [8:0] base;
    logic [7:0] part;

    assign access = psel && penable && !pready;
    assign done_acc = psel && penable && pready;
    assign wr = done_acc && pwrite;
    assign rd = done_acc && !pwrite;
    assign cmd_code = pwdata[smart_pkg::CMD_LSB +: 8];
    assign feat = pwdata[smart_pkg::FEAT_LSB +: 8];
    assign cyl_hi = pwdata[smart_pkg::CYLHI_LSB +: 8];
    assign health = cmd_code == smart_pkg::CMD_HEALTH && cyl_hi == smart_pkg::SIG_CYL_HI;
    // commands written while a sector is streaming are dropped
    assign cmd_go = wr && paddr == smart_pkg::ADDR_CMD && state_q == smart_pkg::ST_IDLE;
    assign supported = health && (feat == smart_pkg::FEAT_READ_DATA || feat == smart_pkg::FEAT_READ_THR ||
                       feat == smart_pkg::FEAT_AUTOSAVE || feat == smart_pkg::FEAT_ENABLE ||
                       feat == smart_pkg::FEAT_DISABLE || feat == smart_pkg::FEAT_STATUS);
    assign data_rd = rd && paddr == smart_pkg::ADDR_DATA && state_q == smart_pkg::ST_XFER;
    assign last_rd = data_rd && idx_q == smart_pkg::LAST_WORD;

    always_comb begin
        base = {idx_q, 2'b00};
        part = 8'(csum_q + sbyte(base) + sbyte(base + 9'h001) + sbyte(base + 9'h002));
        data_word = {sbyte(base + 9'h003), sbyte(base + 9'h002), sbyte(base + 9'h001), sbyte(base)};
        if (idx_q == smart_pkg::LAST_WORD) begin
            data_word[31:24] = 8'(8'h00 - part);
        end
        if (state_q != smart_pkg::ST_XFER) begin
            data_word = '0;
        end
    end

    always_comb begin
        rdata_d = '0;
        err_d = 1'b0;
        if (paddr >= smart_pkg::ADDR_CNT0 && paddr < smart_pkg::ADDR_CNT0 + 8'(4 * smart_pkg::NCNT)) begin
            rdata_d = cnt_q[int'((paddr - smart_pkg::ADDR_CNT0) >> 2)];
        end else if (paddr >= smart_pkg::ADDR_INIT0 && paddr < smart_pkg::ADDR_INIT0 + 8'(4 * smart_pkg::CHIPS)) begin
            rdata_d = 32'(init_q[int'((paddr - smart_pkg::ADDR_INIT0) >> 2)]);
        end else if (paddr >= smart_pkg::ADDR_CUR0 && paddr < smart_pkg::ADDR_CUR0 + 8'(4 * smart_pkg::CHIPS)) begin
            rdata_d = 32'(cur_q[int'((paddr - smart_pkg::ADDR_CUR0) >> 2)]);
        end else begin
            unique case (paddr)
                smart_pkg::ADDR_CMD: rdata_d = '0;
                smart_pkg::ADDR_STATUS: rdata_d = {28'h0000000, thresh_exceeded, abort_q, done_q,
                                                   state_q == smart_pkg::ST_XFER};
                smart_pkg::ADDR_DATA: rdata_d = data_word;
                smart_pkg::ADDR_THRESH: rdata_d = {24'h000000, thr_q};
                smart_pkg::ADDR_FLAGS: rdata_d = {30'h00000000, flags_q};
                default: err_d = 1'b1;
            endcase
        end
    end

    // one wait state: answer registered from the first access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= '0;
        end else begin
            pready <= access;
            pslverr <= access && err_d;
            prdata <= access && !pwrite ? rdata_d : '0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= smart_pkg::ST_IDLE;
            idx_q <= '0;
            csum_q <= '0;
        end else if (cmd_go && supported && feat == smart_pkg::FEAT_READ_DATA) begin
            state_q <= smart_pkg::ST_XFER;
            idx_q <= '0;
            csum_q <= '0;
        end else if (data_rd) begin
            idx_q <= idx_q + 7'h01;
            csum_q <= 8'(csum_q + word_sum(data_word));
            if (last_rd) begin
                state_q <= smart_pkg::ST_IDLE;
            end
        end
    end

    // sticky status; a new event outranks a write-one-to-clear in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            done_q <= 1'b0;
            abort_q <= 1'b0;
        end else begin
            done_q <= (cmd_go && supported && feat != smart_pkg::FEAT_READ_DATA) || last_rd ||
                      (done_q && !(wr && paddr == smart_pkg::ADDR_STATUS && pwdata[smart_pkg::ST_DONE]));
            abort_q <= (cmd_go && !supported) ||
                       (abort_q && !(wr && paddr == smart_pkg::ADDR_STATUS && pwdata[smart_pkg::ST_ABORT]));
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            thr_q <= '0;
            cnt_q <= '0;
            init_q <= '0;
            cur_q <= '0;
        end else if (wr) begin
            if (paddr == smart_pkg::ADDR_THRESH && pstrb[0]) begin
                thr_q <= pwdata[7:0];
            end
            for (int k = 0; k < smart_pkg::NCNT; k++) begin
                if (paddr == smart_pkg::ADDR_CNT0 + 8'(4 * k)) begin
                    cnt_q[k] <= strb_merge(cnt_q[k], pwdata, pstrb);
                end
            end
            for (int c = 0; c < smart_pkg::CHIPS; c++) begin
                if (paddr == smart_pkg::ADDR_INIT0 + 8'(4 * c)) begin
                    init_q[c] <= SPARE_BITS'(strb_merge(32'(init_q[c]), pwdata, pstrb));
                end
                if (paddr == smart_pkg::ADDR_CUR0 + 8'(4 * c)) begin
                    cur_q[c] <= SPARE_BITS'(strb_merge(32'(cur_q[c]), pwdata, pstrb));
                end
            end
        end
    end

    // flags only ever rise; a drained chip raises global bad block handling itself
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flags_q <= '0;
        end else begin
            flags_q[smart_pkg::FLG_GBB] <= flags_q[smart_pkg::FLG_GBB] || chip_empty ||
                (wr && paddr == smart_pkg::ADDR_FLAGS && pwdata[smart_pkg::FLG_GBB]);
            flags_q[smart_pkg::FLG_GWL] <= flags_q[smart_pkg::FLG_GWL] ||
                (wr && paddr == smart_pkg::ADDR_FLAGS && pwdata[smart_pkg::FLG_GWL]);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            worst_q <= smart_pkg::PCT_FULL;
            thresh_exceeded <= 1'b0;
        end else begin
            if (pct < worst_q) begin
                worst_q <= pct;
            end
            thresh_exceeded <= pct < thr_q;
        end
    end

    logic [7:0] chk_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            chk_q <= '0;
        end else if (cmd_go) begin
            chk_q <= '0;
        end else if (data_rd) begin
            chk_q <= 8'(chk_q + word_sum(prdata));
        end
    end

    property p_autosave;
        @(posedge pclk) disable iff (!presetn)
        (cmd_go && health && feat == smart_pkg::FEAT_AUTOSAVE) |=>
        (state_q == smart_pkg::ST_IDLE && $stable(idx_q) && $stable(csum_q) && done_q);
    endproperty
    a_autosave: assert property (p_autosave) else $error("autosave altered state");

    property p_start;
        @(posedge pclk) disable iff (!presetn)
        (cmd_go && supported && feat == smart_pkg::FEAT_READ_DATA) |=> (state_q == smart_pkg::ST_XFER && idx_q == 7'h00);
    endproperty
    a_start: assert property (p_start) else $error("read data did not start");

    property p_end;
        @(posedge pclk) disable iff (!presetn)
        last_rd |=> (state_q == smart_pkg::ST_IDLE && done_q && idx_q == 7'h00);
    endproperty
    a_end: assert property (p_end) else $error("sector not ended after last word");

    property p_version;
        @(posedge pclk) disable iff (!presetn)
        (data_rd && idx_q == 7'h00) |-> prdata[15:0] == smart_pkg::STRUCT_VER;
    endproperty
    a_version: assert property (p_version) else $error("bad structure version");

    property p_offline;
        @(posedge pclk) disable iff (!presetn)
        (data_rd && idx_q == smart_pkg::OFS_OFFL_STAT[8:2]) |-> prdata[31:16] == 16'h0000;
    endproperty
    a_offline: assert property (p_offline) else $error("offline status not zero");

    property p_cap;
        @(posedge pclk) disable iff (!presetn)
        (data_rd && idx_q == smart_pkg::OFS_CAP[8:2]) |-> prdata == {16'h0000, smart_pkg::SMART_CAP};
    endproperty
    a_cap: assert property (p_cap) else $error("capability or error log byte wrong");

    property p_vver;
        @(posedge pclk) disable iff (!presetn)
        (data_rd && idx_q == smart_pkg::OFS_VVER[8:2]) |-> prdata == {smart_pkg::VENDOR_VER, 16'h0000};
    endproperty
    a_vver: assert property (p_vver) else $error("vendor version wrong");

    property p_checksum;
        @(posedge pclk) disable iff (!presetn)
        last_rd |-> 8'(chk_q + word_sum(prdata)) == 8'h00;
    endproperty
    a_checksum: assert property (p_checksum) else $error("sector sum not zero");

    property p_gbb_sticky;
        @(posedge pclk) disable iff (!presetn)
        (flags_q[smart_pkg::FLG_GBB] || chip_empty) |=> flags_q[smart_pkg::FLG_GBB] [*3];
    endproperty
    a_gbb_sticky: assert property (p_gbb_sticky) else $error("bad block flag fell");

    property p_worst;
        @(posedge pclk) disable iff (!presetn)
        ##1 worst_q == (($past(pct) < $past(worst_q)) ? $past(pct) : $past(worst_q));
    endproperty
    a_worst: assert property (p_worst) else $error("worst value rose");

    property p_thresh;
        @(posedge pclk) disable iff (!presetn)
        ##1 thresh_exceeded == ($past(pct) < $past(thr_q));
    endproperty
    a_thresh: assert property (p_thresh) else $error("threshold flag wrong");

    property p_abort;
        @(posedge pclk) disable iff (!presetn)
        (cmd_go && !supported) |=> (abort_q && state_q == smart_pkg::ST_IDLE);
    endproperty
    a_abort: assert property (p_abort) else $error("unsupported feature not aborted");

    c_autosave: cover property (@(posedge pclk) cmd_go && health && feat == smart_pkg::FEAT_AUTOSAVE);
    c_sector: cover property (@(posedge pclk) last_rd);
    c_abort: cover property (@(posedge pclk) cmd_go && !supported);
    c_thresh: cover property (@(posedge pclk) $rose(thresh_exceeded));
endmodule

// ===== tb/host_model.sv
`timescale 1ns/10ps
module host_model (
    input wire logic pclk,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [31:0] prdata,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [7:0] paddr,
    output logic [31:0] pwdata,
    output logic [3:0] pstrb
);
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        pstrb = 4'hF;
    end
    // callers build commands as code B0h, feature, signature C2h
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] q, output logic e, output logic ok);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 40);
        ok = (pready === 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // released lines flip so stale values never look valid
        paddr <= ~a;
        pwdata <= ~d;
    endtask
endmodule

// ===== tb/smart_data_report_tb_top.sv
`timescale 1ns/10ps
module smart_data_report_tb_top;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, thresh_exceeded, err;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic [3:0] pstrb;
    logic [7:0] s [512];
    logic [7:0] e [512];
    logic [7:0] sum;
    int n_fail = 0;
    int compares = 0;
    int ini [4] = '{100, 200, 50, 40};
    int cur [4] = '{90, 100, 50, 20};
    int off [6] = '{388, 392, 398, 402, 406, 410};
    logic [7:0] fe [4] = '{8'hD1, 8'hD8, 8'hD9, 8'hDA};
    smart_data_report DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .thresh_exceeded(thresh_exceeded));
    host_model host (.pclk(pclk), .pready(pready), .pslverr(pslverr), .prdata(prdata), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb));
    always #5 pclk = ~pclk;
    task automatic final_report();
        $display("checks %0d mismatches %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
        logic ok;
        host.xfer(w, a, d, q, err, ok);
        if (!ok) begin
            n_fail++;
            final_report();
        end
    endtask
    initial begin
        pclk = 1'b0;
        presetn = 1'b0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        acc(1'b1, 8'h00, 32'hC200_D2B0);
        acc(1'b0, 8'h04, 32'h0);
        chk("autosave status", q, 32'h2);
        acc(1'b1, 8'h04, 32'h6);
        acc(1'b1, 8'h00, 32'hC200_D3B0);
        acc(1'b0, 8'h04, 32'h0);
        chk("unknown feature", q, 32'h4);
        acc(1'b1, 8'h04, 32'h6);
        acc(1'b0, 8'h2C, 32'h0);
        chk("unmapped error", {31'h0, err}, 32'h1);
        foreach (fe[i]) begin
            acc(1'b1, 8'h00, {8'hC2, 8'h00, fe[i], 8'hB0});
            acc(1'b0, 8'h04, 32'h0);
            chk("other feature", q, 32'h2);
            acc(1'b1, 8'h04, 32'h6);
        end
        acc(1'b1, 8'h00, 32'hC100_D0B0);
        acc(1'b0, 8'h04, 32'h0);
        chk("bad signature", q, 32'h4);
        acc(1'b1, 8'h04, 32'h6);
        // current count first: a chip with initial set and current still zero reads as drained
        for (int i = 0; i < 4; i++) begin
            acc(1'b1, 8'h40 + 8'(4 * i), 32'(cur[i]));
            acc(1'b1, 8'h30 + 8'(4 * i), 32'(ini[i]));
        end
        for (int i = 0; i < 6; i++) acc(1'b1, 8'h14 + 8'(4 * i), 32'h1122_3340 + 32'(i));
        acc(1'b1, 8'h10, 32'h2);
        acc(1'b1, 8'h0C, 32'h3C);
        acc(1'b1, 8'h00, 32'hC200_D0B0);
        for (int i = 0; i < 128; i++) begin
            acc(1'b0, 8'h08, 32'h0);
            {s[4*i+3], s[4*i+2], s[4*i+1], s[4*i]} = q;
        end
        acc(1'b0, 8'h04, 32'h0);
        chk("status after sector", q, 32'hA);
        chk("threshold flag", {31'h0, thresh_exceeded}, 32'h1);
        acc(1'b0, 8'h08, 32'h0);
        chk("word past sector", q, 32'h0);
        // min pct 50, worst chip is chip 3 (40 initial, 20 current)
        foreach (e[i]) e[i] = 8'h00;
        e[0] = 8'h10;
        {e[2], e[3], e[5], e[6], e[7], e[8], e[10], e[11]} = {8'hC4, 8'h03, 8'h32, 8'h32, 8'h86, 8'h01, 8'h04, 8'h01};
        {e[14], e[15], e[17], e[18], e[19], e[22]} = {8'hD5, 8'h03, 8'h64, 8'h64, 8'h28, 8'h14};
        {e[368], e[386], e[397]} = {8'h03, 8'h04, 8'h01};
        for (int i = 0; i < 6; i++) {e[off[i]+3], e[off[i]+2], e[off[i]+1], e[off[i]]} = 32'h1122_3340 + 32'(i);
        sum = 8'h00;
        for (int i = 0; i < 511; i++) sum += e[i];
        e[511] = -sum;
        for (int i = 0; i < 512; i++) begin
            chk($sformatf("byte %0d", i), 32'(s[i]), 32'(e[i]));
        end
        acc(1'b1, 8'h4C, 32'h0);
        acc(1'b0, 8'h10, 32'h0);
        chk("drained chip flag", q, 32'h3);
        final_report();
    end
endmodule
